// ---- pwc_wiper_control.sv ----
module pwc_wiper_control
    import pwc_pkg::*;
#(
    parameter int MS_CYCLES = PWC_MS_CYCLES
) (
    input wire logic clock,              // 250 MHz
    input wire logic rst_n,              // async reset, power-up
    input wire logic mode_select,        // strap, high = independent
    input wire logic up_pot0_button_n,   // also volume_raise_input
    input wire logic down_pot0_button_n, // also volume_lower_input
    input wire logic up_pot1_button_n,   // also balance_toward_wiper0
    input wire logic down_pot1_button_n, // also balance_toward_wiper1
    output logic [6:0] wiper0_pos,       // wiper 0 position
    output logic [6:0] wiper1_pos,       // wiper 1 position
    output logic wiper0_mute,            // wiper 0 at mute
    output logic wiper1_mute,            // wiper 1 at mute
    output logic mode_independent,       // latched mode
    output logic single_button,          // latched single-button setup
    output logic port_ready,             // serial port operational
    output logic buttons_active          // buttons being acted on
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    localparam int MSW = $clog2(MS_CYCLES);

    generate
        if (MS_CYCLES < 2) begin : g_bad_ms
            $error("MS_CYCLES must be at least 2");
        end
    endgenerate

    // ****************************************************************
    // power-up timing
    // ****************************************************************
    logic [11:0] port_cnt;
    logic [MSW-1:0] ms_cnt;
    logic ms_tick;
    logic [10:0] settle_ms;
    pwc_phase_t phase;
    logic [PWC_PINS-1:0] pin_low;

    // contacts close to ground, so a low pin is an active press
    assign pin_low = ~{down_pot1_button_n, up_pot1_button_n,
                       down_pot0_button_n, up_pot0_button_n};

    // serial port readiness counts from reset release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            port_cnt <= 12'h000;
            port_ready <= 1'b0;
        end else if (!port_ready) begin
            port_cnt <= port_cnt + 12'h001;
            port_ready <= (port_cnt == 12'(PWC_PORT_READY_CYCLES - 1));
        end
    end

    // 1 ms enable; all debounce and repeat timing rides on it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ms_cnt <= '0;
            ms_tick <= 1'b0;
        end else begin
            ms_tick <= (ms_cnt == MSW'(MS_CYCLES - 1));
            if (ms_cnt == MSW'(MS_CYCLES - 1)) begin
                ms_cnt <= '0;
            end else begin
                ms_cnt <= ms_cnt + MSW'(1);
            end
        end
    end

    // straps caught on the first edge after release, never under reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PWC_PH_POWERUP;
            settle_ms <= 11'h000;
            mode_independent <= 1'b0;
            single_button <= 1'b0;
            buttons_active <= 1'b0;
        end else begin
            case (phase)
                PWC_PH_POWERUP: begin
                    mode_independent <= mode_select;
                    // down-side pins tied high at power-up pick single-button
                    single_button <= !pin_low[PWC_PIN_B] && !pin_low[PWC_PIN_D];
                    phase <= PWC_PH_SETTLE;
                end
                PWC_PH_SETTLE: begin
                    if (ms_tick) begin
                        settle_ms <= settle_ms + 11'h001;
                        if (settle_ms == PWC_STARTUP_MS - 11'h001) begin
                            buttons_active <= 1'b1;
                            phase <= PWC_PH_RUN;
                        end
                    end
                end
                default: begin
                    phase <= PWC_PH_RUN;
                end
            endcase
        end
    end

    // ****************************************************************
    // per-pin debounce, hold repeat and idle detection
    // ****************************************************************
    logic [PWC_PINS-1:0] step;
    logic [PWC_PINS-1:0] flip;

    generate
        for (genvar i = 0; i < PWC_PINS; i++) begin : g_pin
            logic raw;
            logic filt;
            logic used;
            logic pulse;
            logic idle_flip;
            logic [10:0] hold;
            logic [10:0] idle;

            // two agreeing 1 ms samples: bounces and short gaps merge
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    raw <= 1'b0;
                    filt <= 1'b0;
                    hold <= 11'h000;
                    pulse <= 1'b0;
                end else begin
                    pulse <= 1'b0;
                    if (ms_tick) begin
                        raw <= pin_low[i];
                        if (pin_low[i] == raw) begin
                            filt <= pin_low[i];
                        end
                        if (!filt) begin
                            hold <= 11'h000;
                        end else if (hold == PWC_HOLD_MS) begin
                            hold <= PWC_HOLD_MS - PWC_REPEAT_MS;
                        end else begin
                            hold <= hold + 11'h001;
                        end
                        // first tick of a press, then each repeat point
                        pulse <= filt && buttons_active &&
                                 (hold == 11'h000 || hold == PWC_HOLD_MS);
                    end
                end
            end

            // a long idle after use asks single-button logic to reverse
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    idle <= 11'h000;
                    used <= 1'b0;
                    idle_flip <= 1'b0;
                end else begin
                    idle_flip <= 1'b0;
                    if (ms_tick) begin
                        if (filt) begin
                            idle <= 11'h000;
                            used <= buttons_active;
                        end else if (idle != PWC_IDLE_MS) begin
                            idle <= idle + 11'h001;
                            if (idle == PWC_IDLE_MS - 11'h001 && used) begin
                                used <= 1'b0;
                                idle_flip <= 1'b1;
                            end
                        end
                    end
                end
            end

            assign step[i] = pulse;
            assign flip[i] = idle_flip;
        end
    endgenerate

    // ****************************************************************
    // wiper movement
    // ****************************************************************
    logic [1:0] dir_high;
    logic vol_up;
    logic bal_to0;
    logic bal_held;
    logic [6:0] bal_ref;
    logic [6:0] next_w0;
    logic [6:0] next_w1;
    logic [1:0] next_dir_high;
    logic next_vol_up;
    logic next_bal_to0;
    logic next_bal_held;
    logic [6:0] next_bal_ref;
    logic vol_evt;
    logic bal_evt;

    function automatic logic [6:0] pwc_toward_high(input logic [6:0] pos);
        pwc_toward_high = (pos == PWC_POS_TOP) ? pos : pos - 7'h01;
    endfunction : pwc_toward_high

    function automatic logic [6:0] pwc_toward_low(input logic [6:0] pos);
        pwc_toward_low = (pos >= PWC_POS_BOTTOM) ? pos : pos + 7'h01;
    endfunction : pwc_toward_low

    // decode the shared pins by the latched mode and set the next positions
    always_comb begin
        logic up_r;
        logic dn_r;
        logic b0_r;
        logic b1_r;
        logic [6:0] ref_now;
        up_r = 1'b0;
        dn_r = 1'b0;
        b0_r = 1'b0;
        b1_r = 1'b0;
        ref_now = bal_ref;
        next_w0 = wiper0_pos;
        next_w1 = wiper1_pos;
        next_dir_high = dir_high;
        next_vol_up = vol_up;
        next_bal_to0 = bal_to0;
        next_bal_held = bal_held;
        next_bal_ref = bal_ref;
        vol_evt = 1'b0;
        bal_evt = 1'b0;
        if (mode_independent) begin
            if (single_button) begin
                // one button per wiper, direction from history
                if (flip[PWC_PIN_A]) begin
                    next_dir_high[0] = ~dir_high[0];
                end
                if (flip[PWC_PIN_C]) begin
                    next_dir_high[1] = ~dir_high[1];
                end
                if (step[PWC_PIN_A]) begin
                    next_w0 = dir_high[0] ? pwc_toward_high(wiper0_pos)
                                          : pwc_toward_low(wiper0_pos);
                    if (next_w0 == PWC_POS_TOP || next_w0 == PWC_POS_BOTTOM) begin
                        next_dir_high[0] = (next_w0 == PWC_POS_BOTTOM);
                    end
                end
                if (step[PWC_PIN_C]) begin
                    next_w1 = dir_high[1] ? pwc_toward_high(wiper1_pos)
                                          : pwc_toward_low(wiper1_pos);
                    if (next_w1 == PWC_POS_TOP || next_w1 == PWC_POS_BOTTOM) begin
                        next_dir_high[1] = (next_w1 == PWC_POS_BOTTOM);
                    end
                end
            end else begin
                // up wins if both buttons of a pair land on one tick; ends saturate
                if (step[PWC_PIN_A]) begin
                    next_w0 = pwc_toward_high(wiper0_pos);
                end else if (step[PWC_PIN_B]) begin
                    next_w0 = pwc_toward_low(wiper0_pos);
                end
                if (step[PWC_PIN_C]) begin
                    next_w1 = pwc_toward_high(wiper1_pos);
                end else if (step[PWC_PIN_D]) begin
                    next_w1 = pwc_toward_low(wiper1_pos);
                end
            end
        end else begin
            // stereo: four functions on the shared pins
            if (single_button) begin
                if (flip[PWC_PIN_A]) begin
                    next_vol_up = ~vol_up;
                end
                if (flip[PWC_PIN_C]) begin
                    next_bal_to0 = ~bal_to0;
                end
                up_r = step[PWC_PIN_A] && vol_up;
                dn_r = step[PWC_PIN_A] && !vol_up;
                b0_r = step[PWC_PIN_C] && bal_to0;
                b1_r = step[PWC_PIN_C] && !bal_to0;
            end else begin
                up_r = step[PWC_PIN_A];
                dn_r = step[PWC_PIN_B];
                b0_r = step[PWC_PIN_C];
                b1_r = step[PWC_PIN_D];
            end
            vol_evt = up_r || dn_r;
            bal_evt = !vol_evt && (b0_r || b1_r);
            if (up_r) begin
                next_bal_held = 1'b0;
                if (wiper0_pos != PWC_POS_TOP && wiper1_pos != PWC_POS_TOP) begin
                    next_w0 = wiper0_pos - 7'h01;
                    next_w1 = wiper1_pos - 7'h01;
                end
                if (next_w0 == PWC_POS_TOP || next_w1 == PWC_POS_TOP) begin
                    next_vol_up = 1'b0;
                end
            end else if (dn_r) begin
                next_bal_held = 1'b0;
                if (wiper0_pos < PWC_POS_BOTTOM && wiper1_pos < PWC_POS_BOTTOM) begin
                    next_w0 = wiper0_pos + 7'h01;
                    next_w1 = wiper1_pos + 7'h01;
                end
                if (next_w0 >= PWC_POS_BOTTOM || next_w1 >= PWC_POS_BOTTOM) begin
                    next_vol_up = 1'b1;
                end
            end else if (bal_evt) begin
                // first balance press stores the louder wiper as the target
                if (!bal_held) begin
                    ref_now = (wiper0_pos < wiper1_pos) ? wiper0_pos : wiper1_pos;
                    next_bal_ref = ref_now;
                    next_bal_held = 1'b1;
                end
                if (b0_r) begin
                    if (wiper0_pos > ref_now) begin
                        next_w0 = wiper0_pos - 7'h01;
                    end else begin
                        next_w1 = pwc_toward_low(wiper1_pos);
                    end
                end else begin
                    if (wiper1_pos > ref_now) begin
                        next_w1 = wiper1_pos - 7'h01;
                    end else begin
                        next_w0 = pwc_toward_low(wiper0_pos);
                    end
                end
            end
        end
    end

    // position registers; steps only exist once the buttons are live
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wiper0_pos <= PWC_POS_RESET;
            wiper1_pos <= PWC_POS_RESET;
            wiper0_mute <= 1'b0;
            wiper1_mute <= 1'b0;
        end else begin
            wiper0_pos <= next_w0;
            wiper1_pos <= next_w1;
            wiper0_mute <= (next_w0 == PWC_POS_MUTE);
            wiper1_mute <= (next_w1 == PWC_POS_MUTE);
        end
    end

    // direction and balance memory; wipers start at the bottom, so go up first
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dir_high <= 2'h3;
            vol_up <= 1'b1;
            bal_to0 <= 1'b1;
            bal_held <= 1'b0;
            bal_ref <= PWC_POS_RESET;
        end else begin
            dir_high <= next_dir_high;
            vol_up <= next_vol_up;
            bal_to0 <= next_bal_to0;
            bal_held <= next_bal_held;
            bal_ref <= next_bal_ref;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_PORT_TIME: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(port_ready) |-> port_cnt == 12'(PWC_PORT_READY_CYCLES))
        else $error("serial port ready at wrong time");

    AST_NO_EARLY_STEP: assert property (@(posedge clock) disable iff (!rst_n)
        !buttons_active |-> step == '0 && wiper0_pos == PWC_POS_RESET)
        else $error("button acted on before start-up delay");

    AST_START_POS: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(buttons_active) |-> wiper0_pos == 7'h3F && wiper1_pos == 7'h3F)
        else $error("wipers not at 63 after power-up");

    AST_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
        wiper0_pos <= PWC_POS_MUTE && wiper1_pos <= PWC_POS_MUTE)
        else $error("wiper position out of range");

    AST_MODE_HELD: assert property (@(posedge clock) disable iff (!rst_n)
        phase == PWC_PH_RUN |=> $stable(mode_independent) && $stable(single_button))
        else $error("mode changed after power-up");

    AST_PAIR_SEPARATE: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_independent && !step[PWC_PIN_C] && !step[PWC_PIN_D])
        |=> $stable(wiper1_pos))
        else $error("wiper 1 moved by a wiper 0 button");

    AST_VOL_DIFF: assert property (@(posedge clock) disable iff (!rst_n)
        (!mode_independent && vol_evt)
        |=> (wiper0_pos - wiper1_pos) == $past(wiper0_pos - wiper1_pos))
        else $error("volume step changed wiper difference");

    AST_BAL_BOTTOM: assert property (@(posedge clock) disable iff (!rst_n)
        (bal_evt && wiper0_pos == PWC_POS_BOTTOM && wiper1_pos == PWC_POS_BOTTOM)
        |=> wiper0_pos == PWC_POS_BOTTOM && wiper1_pos == PWC_POS_BOTTOM)
        else $error("balance moved wipers off the bottom");

    AST_DUAL_END: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_independent && !single_button && wiper0_pos == PWC_POS_TOP
         && step[PWC_PIN_A]) |=> wiper0_pos == PWC_POS_TOP)
        else $error("wiper left the top end on an up step");

endmodule : pwc_wiper_control

// ---- pwc_pkg.sv ----
// ****************************************************************
// timing, positions and pin indices
// ****************************************************************
package pwc_pkg;

    // clock period and the times the block measures, in their own units
    localparam int PWC_CLK_NS = 4;
    localparam int PWC_PORT_READY_NS = 10000;
    localparam int PWC_PORT_READY_CYCLES = PWC_PORT_READY_NS / PWC_CLK_NS;
    localparam int PWC_MS_NS = 1000000;
    localparam int PWC_MS_CYCLES = PWC_MS_NS / PWC_CLK_NS;

    // millisecond counts, measured on the 1 ms tick
    localparam logic [10:0] PWC_STARTUP_MS = 11'h032; // 50 ms
    localparam logic [10:0] PWC_HOLD_MS = 11'h3E8;    // 1000 ms
    localparam logic [10:0] PWC_REPEAT_MS = 11'h064;  // 100 ms
    localparam logic [10:0] PWC_IDLE_MS = 11'h3E8;    // 1000 ms

    // wiper positions: 0 is 0 dB, each step adds 1 dB
    localparam logic [6:0] PWC_POS_TOP = 7'h00;
    localparam logic [6:0] PWC_POS_BOTTOM = 7'h3F;
    localparam logic [6:0] PWC_POS_MUTE = 7'h40;
    localparam logic [6:0] PWC_POS_RESET = 7'h3F;

    // shared pin indices (independent name / stereo name)
    localparam int PWC_PIN_A = 0; // up_pot0 / volume raise
    localparam int PWC_PIN_B = 1; // down_pot0 / volume lower
    localparam int PWC_PIN_C = 2; // up_pot1 / balance toward wiper 0
    localparam int PWC_PIN_D = 3; // down_pot1 / balance toward wiper 1
    localparam int PWC_PINS = 4;

    // power-up sequence
    typedef enum logic [1:0] {
        PWC_PH_POWERUP,
        PWC_PH_SETTLE,
        PWC_PH_RUN
    } pwc_phase_t;

endpackage : pwc_pkg

// ---- pwc_button_model.sv ----
// ****************************************************************
// pushbutton contacts with pull-ups, plus the mode strap
// ****************************************************************
module pwc_button_model (
    input wire logic clock,       // bench clock
    input wire logic [3:0] press, // contact closed, one bit a pin
    input wire logic strap_dual,  // hold pins B and D low for the dual setup
    input wire logic mode_high,   // wanted mode level
    output logic [3:0] pin_n,     // contact lines, low while closed
    output logic mode_pin         // mode strap, never left floating
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] chatter = 2'h0;
    logic [3:0] press_d = 4'h0;

    // free-running phase used to make a fresh closure chatter briefly
    always_ff @(posedge clock) begin
        chatter <= chatter + 2'h1;
        press_d <= press;
    end

    // an open contact rests at the pull-up level unless strap_dual holds pins B and D low, never at a stale value
    always_comb begin
        pin_n = ~press;
        // the first cycle of a closure may bounce back open
        for (int k = 0; k < 4; k++) begin
            if (press[k] && !press_d[k]) begin
                pin_n[k] = chatter[0];
            end
        end
        if (strap_dual) begin
            pin_n[1] = 1'b0;
            pin_n[3] = 1'b0;
        end
    end

    // strap always at a defined level
    assign mode_pin = mode_high;
endmodule : pwc_button_model

// ---- testbench.sv ----
module testbench
    import pwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // small tick keeps the second-long holds short in simulation
    localparam int MS = 8;
    localparam int LIMIT = 100000;

    logic clock;
    logic rst_n;
    logic [3:0] press;
    logic strap_dual;
    logic mode_high;
    logic [3:0] pin_n;
    logic mode_pin;
    logic [6:0] wiper0_pos;
    logic [6:0] wiper1_pos;
    logic wiper0_mute;
    logic wiper1_mute;
    logic mode_independent;
    logic single_button;
    logic port_ready;
    logic buttons_active;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    pwc_button_model buttons (.clock(clock), .press(press), .strap_dual(strap_dual),
        .mode_high(mode_high), .pin_n(pin_n), .mode_pin(mode_pin));

    pwc_wiper_control #(.MS_CYCLES(MS)) DUT (.clock(clock), .rst_n(rst_n),
        .mode_select(mode_pin), .up_pot0_button_n(pin_n[0]), .down_pot0_button_n(pin_n[1]),
        .up_pot1_button_n(pin_n[2]), .down_pot1_button_n(pin_n[3]),
        .wiper0_pos(wiper0_pos), .wiper1_pos(wiper1_pos), .wiper0_mute(wiper0_mute),
        .wiper1_mute(wiper1_mute), .mode_independent(mode_independent),
        .single_button(single_button), .port_ready(port_ready),
        .buttons_active(buttons_active));

    // ****************************************************************
    // clock, watchdog and shared tasks
    // ****************************************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task close_out;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // a hang costs one mismatch and ends the run
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures = failures + 1;
            $display("BAD %0t run did not finish", $time);
            close_out();
        end
    end

    // sample at the falling edge so the design's updates have landed
    task chk(input logic [6:0] got, input logic [6:0] exp, input string what);
        @(negedge clock);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("BAD %0t %s got %0d expected %0d", $time, what, got, exp);
        end
        @(posedge clock);
    endtask : chk

    task wait_ms(input int n);
        repeat (n * MS) @(posedge clock);
    endtask : wait_ms

    // closure of n ms, then a release long enough to read as separate
    task push(input int i, input int n, input int times);
        repeat (times) begin
            press[i] <= 1'b1;
            wait_ms(n);
            press[i] <= 1'b0;
            wait_ms(5);
        end
    endtask : push

    task power_up(input logic mode, input logic dual);
        int n;
        rst_n <= 1'b0;
        mode_high <= mode;
        strap_dual <= dual;
        press <= 4'h0;
        repeat (12) @(posedge clock);
        chk(wiper0_pos, PWC_POS_RESET, "wiper 0 in reset");
        rst_n <= 1'b1;
        press[PWC_PIN_A] <= 1'b1;
        repeat (4) @(posedge clock);
        strap_dual <= 1'b0;
        n = 4;
        // early press is let go well before the startup window ends
        while (port_ready !== 1'b1 && n < 3000) begin
            if (n == 30 * MS) begin
                press <= 4'h0;
            end
            @(posedge clock);
            n = n + 1;
        end
        chk({6'h00, port_ready}, 7'h01, "port ready in time");
        chk({6'h00, buttons_active}, 7'h01, "buttons active");
        chk({6'h00, mode_independent}, {6'h00, mode}, "latched mode");
        chk({6'h00, single_button}, {6'h00, ~dual}, "button setup");
        chk(wiper0_pos, 7'h3F, "early press ignored");
        chk(wiper1_pos, 7'h3F, "wiper 1 after power-up");
        chk({6'h00, wiper0_mute}, 7'h00, "no mute at 63");
        chk({6'h00, wiper1_mute}, 7'h00, "no mute wiper 1");
    endtask : power_up

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task test_dual_independent;
        power_up(1'b1, 1'b1);
        press[PWC_PIN_A] <= 1'b1;
        wait_ms(4);
        press[PWC_PIN_A] <= 1'b0;
        repeat (2) @(posedge clock);
        press[PWC_PIN_A] <= 1'b1;
        wait_ms(4);
        press[PWC_PIN_A] <= 1'b0;
        wait_ms(5);
        chk(wiper0_pos, 7'h3E, "short gap merged");
        chk(wiper1_pos, 7'h3F, "other wiper still");
        push(PWC_PIN_D, 5, 1);
        chk(wiper1_pos, 7'h3F, "stays at bottom");
        push(PWC_PIN_C, 5, 1);
        chk(wiper1_pos, 7'h3E, "up wiper 1");
        push(PWC_PIN_B, 5, 2);
        chk(wiper0_pos, 7'h3F, "down then held at end");
        push(PWC_PIN_A, 1250, 1);
        chk(wiper0_pos, 7'h3B, "long hold repeats");
        $display("dual independent test done");
    endtask : test_dual_independent

    task test_single_button;
        power_up(1'b1, 1'b0);
        push(PWC_PIN_A, 5, 2);
        chk(wiper0_pos, 7'h3D, "single button first way");
        wait_ms(1100);
        push(PWC_PIN_A, 5, 1);
        chk(wiper0_pos, 7'h3E, "reversed after idle");
        $display("single button test done");
    endtask : test_single_button

    task test_stereo;
        power_up(1'b0, 1'b1);
        push(PWC_PIN_C, 5, 1);
        chk(wiper0_pos, 7'h3F, "no balance at bottom");
        push(PWC_PIN_A, 5, 3);
        chk(wiper0_pos, 7'h3C, "volume wiper 0");
        chk(wiper1_pos, 7'h3C, "volume wiper 1");
        push(PWC_PIN_C, 5, 1);
        chk(wiper1_pos, 7'h3D, "equal then other drops");
        push(PWC_PIN_D, 5, 2);
        chk(wiper1_pos, 7'h3C, "mirror balance");
        chk(wiper0_pos, 7'h3D, "mirror drops wiper 0");
        push(PWC_PIN_C, 5, 2);
        chk(wiper0_pos, 7'h3C, "balance lifts wiper 0");
        chk(wiper1_pos, 7'h3D, "then wiper 1 drops");
        push(PWC_PIN_B, 5, 3);
        chk(wiper0_pos, 7'h3E, "volume stops at end");
        chk(wiper1_pos, 7'h3F, "wiper 1 at end");
        push(PWC_PIN_C, 5, 1);
        chk(wiper0_pos, 7'h3E, "balance idle at bottom");
        chk(wiper1_pos, 7'h3F, "wiper 1 unmoved");
        $display("stereo test done");
    endtask : test_stereo

    // stereo with one button each for volume and balance
    task test_single_stereo;
        power_up(1'b0, 1'b0);
        push(PWC_PIN_A, 5, 2);
        chk(wiper0_pos, 7'h3D, "single volume wiper 0");
        chk(wiper1_pos, 7'h3D, "single volume wiper 1");
        push(PWC_PIN_C, 5, 1);
        chk(wiper1_pos, 7'h3E, "single balance drops wiper 1");
        chk(wiper0_pos, 7'h3D, "single balance keeps wiper 0");
        $display("single stereo test done");
    endtask : test_single_stereo

    initial begin
        rst_n = 1'b0;
        press = 4'h0;
        strap_dual = 1'b0;
        mode_high = 1'b1;
        test_dual_independent();
        test_single_button();
        test_stereo();
        test_single_stereo();
        close_out();
    end
endmodule : testbench
